// File: shared/psr_pkg.sv
// Shared constants and types for the port, serial master and RF control block
package psr_pkg;

    // Special-function-register addresses
    localparam logic [7:0] ADDR_PORT0_DATA   = 8'h80;  // Port 0 data
    localparam logic [7:0] ADDR_PORT0_DIR    = 8'h94;  // Port 0 direction
    localparam logic [7:0] ADDR_PORT0_FSEL   = 8'h95;  // Port 0 function select
    localparam logic [7:0] ADDR_PORT1_DATA   = 8'h90;  // Port 1 data
    localparam logic [7:0] ADDR_PORT1_DIR    = 8'h96;  // Port 1 direction
    localparam logic [7:0] ADDR_PORT1_FSEL   = 8'h97;  // Port 1 function select
    localparam logic [7:0] ADDR_RF_CTRL      = 8'ha0;  // Transmitter control port
    localparam logic [7:0] ADDR_SER_ROUTE    = 8'hb3;  // Serial routing select
    localparam logic [7:0] ADDR_SER_DATA     = 8'hb2;  // Serial shift data
    localparam logic [7:0] ADDR_SER_DIV      = 8'hb4;  // Serial clock divider
    localparam logic [7:0] ADDR_EXT_IRQ_FLAG = 8'h91;  // Extended interrupt flags

    // Reset values
    localparam logic [7:0] RST_DIR      = 8'hff;  // Direction 1 = input
    localparam logic [7:0] RST_FSEL     = 8'h00;  // No alternate function
    localparam logic [7:0] RST_DATA     = 8'h00;  // Output latch
    localparam logic [7:0] RST_RF_CTRL  = 8'h80;  // Power-up high, others low
    localparam logic [1:0] RST_ROUTE    = 2'h0;   // Serial master unrouted
    localparam logic [7:0] RST_SER_DIV  = 8'h00;  // Fastest serial clock

    // Field positions
    localparam int EXTENDED_INTERRUPT_FLAGS_SER_DONE_BIT = 5;  // Serial-done flag in extended flags
    localparam int RF_CFG_SEL_BIT    = 3;  // Transmitter config select
    localparam int RF_CLK_BIT        = 4;  // Transmitter serial clock line
    localparam int RF_DATA_BIT       = 5;  // Transmitter serial data line
    localparam int RF_TX_EN_BIT      = 6;  // Transmitter TX enable
    localparam int RF_RF_POWER_UP_BIT     = 7;  // Transmitter power-up
    localparam int P0_UART_RX_BIT    = 1;  // Port 0 UART receive pin
    localparam int P1_IMPL_BITS      = 3;  // Implemented port 1 bits

    // Port 0 bits whose alternate function is an output
    localparam logic [7:0] PORT0_FUNCTION_SELECT_OUT_MASK = 8'h84;

    // Routing select codes
    localparam logic [1:0] ROUTE_PORT1 = 2'h1;  // Serial master on port 1

    // Serial timing
    localparam int SER_BITS        = 8;  // Bits per transfer
    localparam int SER_DONE_CYCLES = 7;  // Clocks from last pulse to flag

    // Serial master states, one-hot
    typedef enum logic [4:0] {
        SER_IDLE = 5'b00001,
        SER_LEAD = 5'b00010,
        SER_HIGH = 5'b00100,
        SER_LOW  = 5'b01000,
        SER_TAIL = 5'b10000
    } psr_ser_state_t;

    // Drive bundle for an eight-bit port
    typedef struct packed {
        logic [7:0] dout;  // Output level
        logic [7:0] oe;    // Output enable, high drives
    } psr_pin_drive_t;

endpackage : psr_pkg

// File: logic/psr_port_spi_radio.sv
// Operation
// RULE1: Internal reset forces all port pins input
// RULE2: Pins stay inputs until software reprograms
// RULE3: Port 0 function select beats direction
// RULE4: Alternate function sets direction, except UART receive
// RULE5: Software enables external interrupts via function select
// RULE6: No alternate function means direction-bit GPIO
// RULE7: Port 0 bit 0 always GPIO
// RULE8: Port 0 uses data, direction, select registers
// RULE9: Routing 01 puts serial master on port 1
// RULE10: Otherwise function bit 0 selects timer input
// RULE11: Port 1 bit 2 input only
// RULE12: Port 1 registers keep three low bits
// RULE13: Data write sends eight MSB-first clock pulses
// RULE14: Done flag raised, received byte readable
// RULE15: Software clears done flag before next write
// RULE16: Divider sets period, half-period lead
// RULE17: Done flag seven clocks after last pulse
// RULE18: Routing upper bit links master to transmitter
// RULE19: Reset forces transmitter control to 0x80
// RULE20: Control port and routing at own addresses
// RULE21: Software frames burst data with TX enable
// RULE22: Falling TX enable launches transmitter burst
// RULE23: Serial master drives no chip select
// RULE24: Software never raises config and TX together
// RULE25: Done flag and request hold until cleared
`timescale 1ns/1ps
module psr_port_spi_radio
    import psr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // Special-function-register bus
    input  wire logic [7:0]  SFR_ADDR_I,
    input  wire logic        SFR_WR_I,
    input  wire logic [7:0]  SFR_WDATA_I,
    output logic      [7:0]  SFR_RDATA_O,
    // Port 0 pins
    input  wire logic [7:0]  P0_PIN_I,
    output logic      [7:0]  P0_PIN_O,
    output logic      [7:0]  P0_PIN_OE_O,
    // Port 1 pins
    input  wire logic [2:0]  P1_PIN_I,
    output logic      [2:0]  P1_PIN_O,
    output logic      [2:0]  P1_PIN_OE_O,
    // Alternate functions of port 0 and timer input
    input  wire logic [7:0]  ALT_OUT_I,
    output logic      [7:0]  ALT_IN_O,
    output logic      [7:0]  ALT_EN_O,
    output logic             T2_IN_O,
    // Transmitter control lines
    input  wire logic        RF_DOUT_I,
    output logic      [7:0]  RF_CTRL_O,
    // Serial-done interrupt request
    output logic             SER_IRQ_O
);

    // Register file
    logic [7:0] port0_pin_data_reg;          // Port 0 output latch
    logic [7:0] port0_direction_reg;         // Port 0 direction, 1 = input
    logic [7:0] port0_function_select_reg;   // Port 0 alternate select
    logic [2:0] port1_pin_data_reg;          // Port 1 output latch
    logic [2:0] port1_direction_reg;         // Port 1 direction
    logic [2:0] port1_function_select_reg;   // Port 1 select, no effect
    logic [7:0] rf_control_port_reg;         // Transmitter control latch
    logic [1:0] serial_routing_select_reg;   // Serial routing
    logic [7:0] serial_clock_divider_reg;    // Half period minus one
    logic       ser_done_reg;                // Serial-done flag

    // Serial master state
    psr_ser_state_t ser_state_reg;           // Sequencer state
    logic [7:0]     ser_shift_reg;           // Shift register and data
    logic           ser_sck_reg;             // Serial clock
    logic           ser_sdo_reg;             // Serial data out
    logic [7:0]     ser_half_cnt_reg;        // Half-period countdown
    logic [3:0]     ser_bit_cnt_reg;         // Rising edges so far
    logic [2:0]     ser_tail_cnt_reg;        // Clocks after last pulse

    // Pin synchronisers
    logic [7:0] p0_meta_reg;                 // First stage port 0
    logic [7:0] p0_sync_reg;                 // Second stage port 0
    logic [2:0] p1_meta_reg;                 // First stage port 1
    logic [2:0] p1_sync_reg;                 // Second stage port 1

    // Decoded strobes and derived signals
    logic           wr_p0_data;              // Write to port 0 data
    logic           wr_ser_data;             // Write to serial data
    logic           ser_go;                  // Accepted transfer start
    logic           ser_done_clear;          // Software clears done flag
    logic           half_tick;               // Half-period enable pulse
    logic           route_p1;                // Master on port 1
    logic           route_rf;                // Master on transmitter
    logic           ser_sdi;                 // Selected serial input
    logic [7:0]     port0_function_select_eff;              // Effective port 0 selects
    psr_pin_drive_t p0_drive;                // Port 0 drive bundle

    // Address match helper
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        hit = SFR_WR_I && (addr == reg_addr);
    endfunction : hit

    // Write strobes
    assign wr_p0_data     = hit(SFR_ADDR_I, ADDR_PORT0_DATA);
    assign wr_ser_data    = hit(SFR_ADDR_I, ADDR_SER_DATA);
    assign ser_go         = wr_ser_data && (ser_state_reg == SER_IDLE);
    assign ser_done_clear = hit(SFR_ADDR_I, ADDR_EXT_IRQ_FLAG) && !SFR_WDATA_I[EXTENDED_INTERRUPT_FLAGS_SER_DONE_BIT];
    assign route_p1       = (serial_routing_select_reg == ROUTE_PORT1);
    assign route_rf       = serial_routing_select_reg[1];
    assign half_tick      = (ser_half_cnt_reg == 8'h00);

    // Two-flop synchronisers on all pin inputs
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            p0_meta_reg <= 8'h00;
            p0_sync_reg <= 8'h00;
            p1_meta_reg <= 3'h0;
            p1_sync_reg <= 3'h0;
        end else begin
            p0_meta_reg <= P0_PIN_I;
            p0_sync_reg <= p0_meta_reg;
            p1_meta_reg <= P1_PIN_I;
            p1_sync_reg <= p1_meta_reg;
        end
    end

    // Port 0 registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            // Every pin comes out of reset as an input
            port0_pin_data_reg        <= RST_DATA;
            port0_direction_reg       <= RST_DIR;   // RULE1
            port0_function_select_reg <= RST_FSEL;  // RULE2
        end else begin
            // Data, direction and select at their own addresses
            if (wr_p0_data) begin
                port0_pin_data_reg <= SFR_WDATA_I;  // RULE8
            end
            if (hit(SFR_ADDR_I, ADDR_PORT0_DIR)) begin
                port0_direction_reg <= SFR_WDATA_I;
            end
            if (hit(SFR_ADDR_I, ADDR_PORT0_FSEL)) begin
                port0_function_select_reg <= SFR_WDATA_I;
            end
        end
    end

    // Port 1 registers, only the low three bits exist
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            port1_pin_data_reg        <= RST_DATA[2:0];
            port1_direction_reg       <= RST_DIR[2:0];   // RULE1
            port1_function_select_reg <= RST_FSEL[2:0];
        end else begin
            if (hit(SFR_ADDR_I, ADDR_PORT1_DATA)) begin
                port1_pin_data_reg <= SFR_WDATA_I[2:0];  // RULE12
            end
            if (hit(SFR_ADDR_I, ADDR_PORT1_DIR)) begin
                port1_direction_reg <= SFR_WDATA_I[2:0];
            end
            if (hit(SFR_ADDR_I, ADDR_PORT1_FSEL)) begin
                port1_function_select_reg <= SFR_WDATA_I[2:0];
            end
        end
    end

    // Transmitter control, routing and divider registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rf_control_port_reg       <= RST_RF_CTRL;  // RULE19
            serial_routing_select_reg <= RST_ROUTE;
            serial_clock_divider_reg  <= RST_SER_DIV;
        end else begin
            if (hit(SFR_ADDR_I, ADDR_RF_CTRL)) begin
                rf_control_port_reg <= SFR_WDATA_I;  // RULE20
            end
            if (hit(SFR_ADDR_I, ADDR_SER_ROUTE)) begin
                serial_routing_select_reg <= SFR_WDATA_I[1:0];
            end
            if (hit(SFR_ADDR_I, ADDR_SER_DIV)) begin
                serial_clock_divider_reg <= SFR_WDATA_I;
            end
        end
    end

    // Port 0 pin function: select first, direction second
    always_comb begin
        port0_function_select_eff = port0_function_select_reg;
        port0_function_select_eff[0] = 1'b0;  // RULE7
        for (int n = 0; n < 8; n++) begin
            if (port0_function_select_eff[n]) begin
                // Alternate function owns the pin
                p0_drive.dout[n] = ALT_OUT_I[n];                            // RULE3
                if (n == P0_UART_RX_BIT) begin
                    p0_drive.oe[n] = !port0_direction_reg[n];               // RULE4
                end else begin
                    p0_drive.oe[n] = PORT0_FUNCTION_SELECT_OUT_MASK[n];
                end
            end else begin
                // Plain GPIO under its direction bit
                p0_drive.dout[n] = port0_pin_data_reg[n];
                p0_drive.oe[n]   = !port0_direction_reg[n];                 // RULE6
            end
        end
    end

    // Port 0 outputs and alternate inputs; interrupts only when selected
    assign P0_PIN_O    = p0_drive.dout;
    assign P0_PIN_OE_O = p0_drive.oe;
    assign ALT_IN_O    = p0_sync_reg;
    assign ALT_EN_O    = port0_function_select_eff;  // RULE5

    // Port 1 pin function
    always_comb begin
        if (route_p1) begin
            // Serial master: clock and data out, bit 2 is serial in
            P1_PIN_O    = {1'b0, ser_sdo_reg, ser_sck_reg};  // RULE9
            P1_PIN_OE_O = 3'h3;
        end else begin
            // GPIO, bit 0 may be the timer input
            P1_PIN_O       = {1'b0, port1_pin_data_reg[1:0]};
            P1_PIN_OE_O[0] = !port1_direction_reg[0] && !port0_function_select_reg[0];  // RULE10
            P1_PIN_OE_O[1] = !port1_direction_reg[1];
            P1_PIN_OE_O[2] = 1'b0;  // RULE11
        end
    end

    // Timer input follows port 1 bit 0 when selected
    assign T2_IN_O = !route_p1 && port0_function_select_reg[0] && p1_sync_reg[0];

    // Serial input source follows the routing
    always_comb begin
        if (route_rf) begin
            ser_sdi = RF_DOUT_I;
        end else if (route_p1) begin
            ser_sdi = p1_sync_reg[2];
        end else begin
            ser_sdi = 1'b0;
        end
    end

    // Transmitter lines, clock and data taken over by the master in 1x
    always_comb begin
        RF_CTRL_O = rf_control_port_reg;  // RULE22
        if (route_rf) begin
            RF_CTRL_O[RF_CLK_BIT]  = ser_sck_reg;  // RULE18
            RF_CTRL_O[RF_DATA_BIT] = ser_sdo_reg;
        end
    end

    // Serial sequencer; no chip select is produced here
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ser_state_reg    <= SER_IDLE;  // RULE23
            ser_shift_reg    <= 8'h00;
            ser_sck_reg      <= 1'b0;
            ser_sdo_reg      <= 1'b0;
            ser_half_cnt_reg <= 8'h00;
            ser_bit_cnt_reg  <= 4'h0;
            ser_tail_cnt_reg <= 3'h0;
        end else begin
            // Divider reloads every half period
            if (ser_state_reg == SER_IDLE || half_tick) begin
                ser_half_cnt_reg <= serial_clock_divider_reg;  // RULE16
            end else begin
                ser_half_cnt_reg <= ser_half_cnt_reg - 8'h01;
            end
            case (ser_state_reg)
                SER_IDLE: begin
                    // Writes while busy are ignored
                    if (ser_go) begin
                        ser_shift_reg   <= SFR_WDATA_I;
                        ser_sdo_reg     <= SFR_WDATA_I[7];  // RULE13
                        ser_bit_cnt_reg <= 4'h0;
                        ser_state_reg   <= SER_LEAD;
                    end
                end
                SER_LEAD, SER_LOW: begin
                    // Rising edge samples serial input
                    if (half_tick) begin
                        ser_sck_reg     <= 1'b1;
                        ser_shift_reg   <= {ser_shift_reg[6:0], ser_sdi};
                        ser_bit_cnt_reg <= ser_bit_cnt_reg + 4'h1;
                        ser_state_reg   <= SER_HIGH;
                    end
                end
                SER_HIGH: begin
                    // Falling edge presents next bit
                    if (half_tick) begin
                        ser_sck_reg <= 1'b0;
                        ser_sdo_reg <= ser_shift_reg[7];
                        if (ser_bit_cnt_reg == 4'(SER_BITS)) begin
                            ser_tail_cnt_reg <= 3'h0;
                            ser_state_reg    <= SER_TAIL;
                        end else begin
                            ser_state_reg <= SER_LOW;
                        end
                    end
                end
                SER_TAIL: begin
                    // Wait out the delay before flagging done
                    if (ser_tail_cnt_reg == 3'(SER_DONE_CYCLES - 1)) begin
                        ser_state_reg <= SER_IDLE;  // RULE17
                    end else begin
                        ser_tail_cnt_reg <= ser_tail_cnt_reg + 3'h1;
                    end
                end
                default: begin
                    ser_state_reg <= SER_IDLE;
                end
            endcase
        end
    end

    // Serial-done flag, setting wins over a simultaneous clear
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ser_done_reg <= 1'b0;
        end else if (ser_state_reg == SER_TAIL && ser_tail_cnt_reg == 3'(SER_DONE_CYCLES - 1)) begin
            ser_done_reg <= 1'b1;  // RULE14
        end else if (ser_done_clear) begin
            ser_done_reg <= 1'b0;  // RULE25
        end
    end

    // Interrupt request holds while the flag is set
    assign SER_IRQ_O = ser_done_reg;

    // Read mux; driven pins read the level they drive, others the pin
    always_comb begin
        case (SFR_ADDR_I)
            ADDR_PORT0_DATA:   SFR_RDATA_O = (p0_drive.oe & p0_drive.dout) | (~p0_drive.oe & p0_sync_reg);
            ADDR_PORT0_DIR:    SFR_RDATA_O = port0_direction_reg;
            ADDR_PORT0_FSEL:   SFR_RDATA_O = port0_function_select_reg;
            ADDR_PORT1_DATA:   SFR_RDATA_O = {5'h00, (P1_PIN_OE_O & P1_PIN_O) | (~P1_PIN_OE_O & p1_sync_reg)};
            ADDR_PORT1_DIR:    SFR_RDATA_O = {5'h00, port1_direction_reg};
            ADDR_PORT1_FSEL:   SFR_RDATA_O = {5'h00, port1_function_select_reg};
            ADDR_RF_CTRL:      SFR_RDATA_O = rf_control_port_reg;
            ADDR_SER_ROUTE:    SFR_RDATA_O = {6'h00, serial_routing_select_reg};
            ADDR_SER_DATA:     SFR_RDATA_O = ser_shift_reg;
            ADDR_SER_DIV:      SFR_RDATA_O = serial_clock_divider_reg;
            ADDR_EXT_IRQ_FLAG: SFR_RDATA_O = {2'h0, ser_done_reg, 5'h00};
            default:           SFR_RDATA_O = 8'h00;
        endcase
    end

    // Checks on pin direction
    property p_reset_inputs;
        @(posedge CLK_I) $rose(ARST_N_I) |-> (P0_PIN_OE_O == 8'h00) && (P1_PIN_OE_O == 3'h0);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("Pins not inputs after reset");  // RULE1

    property p_bit0_gpio;
        @(posedge CLK_I) disable iff (!ARST_N_I) P0_PIN_OE_O[0] == !port0_direction_reg[0];
    endproperty
    a_bit0_gpio: assert property (p_bit0_gpio) else $error("Port 0 bit 0 left GPIO");  // RULE7

    property p_gpio_dir;
        @(posedge CLK_I) disable iff (!ARST_N_I)
            ((~port0_function_select_eff & P0_PIN_OE_O) == (~port0_function_select_eff & ~port0_direction_reg));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("GPIO direction mismatch");  // RULE6

    property p_alt_dir;
        @(posedge CLK_I) disable iff (!ARST_N_I)
            port0_function_select_eff[7] |-> P0_PIN_OE_O[7] && (P0_PIN_OE_O[3] == (!port0_function_select_eff[3] && !port0_direction_reg[3]));
    endproperty
    a_alt_dir: assert property (p_alt_dir) else $error("Alternate direction wrong");  // RULE4

    property p_p1_input;
        @(posedge CLK_I) disable iff (!ARST_N_I) !P1_PIN_OE_O[2];
    endproperty
    a_p1_input: assert property (p_p1_input) else $error("Port 1 bit 2 driven");  // RULE11

    // Checks on serial master and transmitter lines
    property p_eight_pulses;
        @(posedge CLK_I) disable iff (!ARST_N_I)
            $rose(ser_state_reg == SER_TAIL) |-> (ser_bit_cnt_reg == 4'h8) && !ser_sck_reg;
    endproperty
    a_eight_pulses: assert property (p_eight_pulses) else $error("Not eight clock pulses");  // RULE13

    property p_lead_half;
        @(posedge CLK_I) disable iff (!ARST_N_I)
            ser_go && (serial_clock_divider_reg == 8'h01) |=> !ser_sck_reg ##1 !ser_sck_reg ##1 ser_sck_reg;
    endproperty
    a_lead_half: assert property (p_lead_half) else $error("Lead time not half period");  // RULE16

    property p_done_delay;
        @(posedge CLK_I) disable iff (!ARST_N_I)
            $rose(ser_state_reg == SER_TAIL) |-> !ser_done_reg [*7] ##1 ser_done_reg;
    endproperty
    a_done_delay: assert property (p_done_delay) else $error("Done flag not seven clocks late");  // RULE17

    property p_done_hold;
        @(posedge CLK_I) disable iff (!ARST_N_I) ser_done_reg && !ser_done_clear |=> ser_done_reg && SER_IRQ_O;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("Done flag dropped");  // RULE25

    property p_rf_reset;
        @(posedge CLK_I) $rose(ARST_N_I) |-> RF_CTRL_O[RF_RF_POWER_UP_BIT] && !RF_CTRL_O[RF_TX_EN_BIT]
            && !RF_CTRL_O[RF_CFG_SEL_BIT];
    endproperty
    a_rf_reset: assert property (p_rf_reset) else $error("Transmitter defaults wrong");  // RULE19

    property p_rf_direct;
        @(posedge CLK_I) disable iff (!ARST_N_I) !route_rf |-> RF_CTRL_O == rf_control_port_reg;
    endproperty
    a_rf_direct: assert property (p_rf_direct) else $error("Transmitter lines overridden");  // RULE18

endmodule : psr_port_spi_radio

// File: tb/psr_spi_slave_model.sv
`timescale 1ns/1ps
// Serial peripheral on port 1, selected by a port 0 line
module psr_spi_slave_model (
    // Clock and serial lines
    input  wire logic       clk_i,
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    input  wire logic       mosi_i,
    // Byte exchange
    input  wire logic [7:0] tx_byte_i,
    output logic            miso_o,
    output logic      [7:0] rx_byte_o
);
    logic [7:0] shift_reg = 8'h00; // Outgoing bits
    logic       sck_reg   = 1'b0;  // Clock seen last cycle
    logic       idle_reg  = 1'b0;  // Toggles every clock, shown while deselected
    // Reload while idle, shift on falling clock, capture on rising clock
    always_ff @(posedge clk_i) begin
        sck_reg  <= sck_i;
        idle_reg <= ~idle_reg;
        if (cs_n_i) begin
            shift_reg <= tx_byte_i;
        end else if (sck_reg && !sck_i) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
        end
        if (!cs_n_i && !sck_reg && sck_i) begin
            rx_byte_o <= {rx_byte_o[6:0], mosi_i};
        end
    end
    // Released line never holds the last bit
    assign miso_o = cs_n_i ? idle_reg : shift_reg[7];
endmodule : psr_spi_slave_model

// File: tb/test_port_spi_radio_ctrl.sv
`timescale 1ns/1ps
module test_port_spi_radio_ctrl;
    import psr_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, sck_d = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, alt_out = 8'h00, tx_byte = 8'h00, d, f, b;
    logic [1:0] p1_in = 2'h0, route = 2'h0;
    logic [31:0] seed = 32'd61;
    int miscompares = 0, compares = 0, pulses = 0, cyc = 0, n;
    wire [7:0] rdata, p0_out, p0_oe, alt_in, alt_en, rf_ctrl, rx_byte;
    wire [2:0] p1_out, p1_oe;
    wire t2_in, irq, miso;
    wire sck_w = route[1] ? rf_ctrl[RF_CLK_BIT] : p1_out[0]; // Serial clock on the active route
    psr_port_spi_radio psr_port_spi_radio_i (.CLK_I(clk), .ARST_N_I(arst_n), .SFR_ADDR_I(addr),
        .SFR_WR_I(wr_en), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .P0_PIN_I(8'h5a), .P0_PIN_O(p0_out),
        .P0_PIN_OE_O(p0_oe), .P1_PIN_I({miso, p1_in}), .P1_PIN_O(p1_out), .P1_PIN_OE_O(p1_oe),
        .ALT_OUT_I(alt_out), .ALT_IN_O(alt_in), .ALT_EN_O(alt_en), .T2_IN_O(t2_in),
        .RF_DOUT_I(1'b1), .RF_CTRL_O(rf_ctrl), .SER_IRQ_O(irq));
    psr_spi_slave_model psr_spi_slave_model_i (.clk_i(clk), .sck_i(p1_out[0]), .cs_n_i(p0_out[5]),
        .mosi_i(p1_out[1]), .tx_byte_i(tx_byte), .miso_o(miso), .rx_byte_o(rx_byte));
    initial forever #10 clk = ~clk;
    // Count serial clock pulses, cut a hang short
    always @(posedge clk) begin
        sck_d <= sck_w;
        if (sck_w && !sck_d) pulses <= pulses + 1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            close_out();
        end
    end
    function logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    // Port 0 drivers: select beats direction, bit 0 stays plain
    function automatic logic [7:0] exp_oe0(input logic [7:0] dir, input logic [7:0] sel);
        logic [7:0] s;
        s = sel & 8'hfe;
        return (~dir & ~s) | (s & PORT0_FUNCTION_SELECT_OUT_MASK) | (s & ~dir & 8'h02);
    endfunction : exp_oe0
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        #1;
        chk($sformatf("reg %h", a), rdata, exp);
    endtask : rd
    // One byte through the serial master; lead half plus 15 halves to the last fall, then the done delay
    task automatic xfer(input logic [1:0] r, input logic [7:0] dv);
        int p;
        route = r;
        wr(ADDR_SER_ROUTE, {6'h00, r});
        wr(ADDR_SER_DIV, dv);
        tx_byte = rnd();
        b = rnd();
        wr(ADDR_PORT0_DATA, 8'h00);
        p = pulses;
        wr(ADDR_SER_DATA, b);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 300);
        chk("done delay", n[7:0], 8'(16 * (dv + 1) + SER_DONE_CYCLES));
        chk("sck pulses", 8'(pulses - p), 8'h08);
        repeat (20) @(posedge clk);
        chk("irq held", {7'h00, irq}, 8'h01);
        rd(ADDR_EXT_IRQ_FLAG, 8'h20);
        rd(ADDR_SER_DATA, r[1] ? 8'hff : tx_byte);
        if (!r[1]) chk("peer rx", rx_byte, b);
        wr(ADDR_EXT_IRQ_FLAG, 8'h00);
        @(posedge clk);
        #1;
        chk("irq clear", {7'h00, irq}, 8'h00);
        wr(ADDR_PORT0_DATA, 8'h20);
    endtask : xfer
    task close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(posedge clk);
        chk("oe in reset", p0_oe, 8'h00);
        chk("rf in reset", rf_ctrl, 8'h80);
        arst_n <= 1'b1;
        rd(ADDR_PORT0_DIR, 8'hff);
        rd(ADDR_RF_CTRL, 8'h80);
        rd(ADDR_SER_ROUTE, 8'h00);
        rd(8'h81, 8'h00);
        wr(ADDR_PORT1_DIR, 8'hff);
        rd(ADDR_PORT1_DIR, 8'h07);
        for (int i = 0; i < 24; i++) begin
            d = rnd();
            f = (i < 4) ? 8'h00 : rnd();
            @(posedge clk);
            alt_out <= rnd();
            wr(ADDR_PORT0_DIR, d);
            wr(ADDR_PORT0_FSEL, f);
            chk("p0 oe", p0_oe, exp_oe0(d, f));
            chk("p0 sel", alt_en, f & 8'hfe);
            chk("port0_function_select", p0_out & f & 8'h84, alt_out & f & 8'h84);
        end
        wr(ADDR_PORT0_FSEL, 8'h00);
        wr(ADDR_PORT1_DIR, 8'h00);
        chk("p1 oe", {5'h00, p1_oe}, 8'h03);
        wr(ADDR_PORT0_FSEL, 8'h01);
        chk("p1 oe t2", {5'h00, p1_oe}, 8'h02);
        @(posedge clk);
        p1_in <= 2'h1;
        repeat (3) @(posedge clk);
        #1;
        chk("t2 in", {7'h00, t2_in}, 8'h01);
        wr(ADDR_PORT0_DATA, 8'h20);
        wr(ADDR_PORT0_DIR, 8'hdf);
        wr(ADDR_PORT0_FSEL, 8'h00);
        wr(ADDR_SER_DIV, 8'h07);
        d = rnd() & 8'hf7;
        wr(ADDR_RF_CTRL, d);
        chk("rf lines", rf_ctrl, d);
        xfer(ROUTE_PORT1, 8'h07);
        xfer(ROUTE_PORT1, 8'h07);
        wr(ADDR_RF_CTRL, d | 8'h40);
        xfer(2'h2, 8'h01);
        chk("rf other", rf_ctrl & 8'hcf, (d | 8'h40) & 8'hcf);
        wr(ADDR_RF_CTRL, d & 8'hbf);
        chk("rf tx off", rf_ctrl & 8'hcf, d & 8'h8f);
        close_out();
    end
endmodule : test_port_spi_radio_ctrl
